// File: hw/dsf_feed_top.sv
// device-side clocking and capture of the ddr sample feed
// Overview of operation
// - the half-rate clock output always toggles at half the conversion rate.
// - an internal strobe captures each sample mid-window of the forward clock.
// - each forwarded edge latches one sample, alternating upper and lower.
// - the half-rate output changes only on a conversion clock rising edge.
// - output phase is 0 or 180 degrees and no reset changes it.
// - the lock controller counts forwarded edges only while i_ctl_enable is high.
// - with the internal fifo enabled no fixed latency is given.
// - several devices' half-rate clocks align only within two periods.
`timescale 1ns/100ps
module dsf_feed_top
    import dsf_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_phase_strap,
    input wire logic i_ctl_enable,
    input wire logic i_fifo_enable,
    input wire logic i_forwarded_sample_clock,
    input wire dsf_sample_t i_sample_bus,
    input wire logic i_ready,
    output logic o_half_rate_clock_output,
    output logic o_valid,
    output dsf_sample_t o_upper_sample_path,
    output dsf_sample_t o_lower_sample_path,
    output logic o_latency_fixed,
    output logic o_locked
);
    // i_ref_clk stands for the conversion clock; one flop divides it
    logic div_q, div_d;
    logic phase_q, phase_d;
    logic phase_set_q, phase_set_d;
    logic [1:0] fclk_s_q, fclk_s_d;
    dsf_sample_t bus_s0_q, bus_s0_d, bus_s1_q, bus_s1_d;
    logic fclk_prev_q, fclk_prev_d;
    logic [2:0] arm_q, arm_d;
    logic edge_seen;
    logic strobe_q, strobe_d;
    dsf_sample_t upper_q, upper_d, lower_q, lower_d;
    logic sel_q, sel_d;
    logic pair_v_q, pair_v_d;
    dsf_ctl_t ctl_q, ctl_d;
    logic [3:0] lock_q, lock_d;
    dsf_pair_if pair_if ();

    // phase is caught once from a strap on the first clock edge, reset or not, then held
    always_comb begin
        phase_d = phase_q;
        phase_set_d = 1'b1;
        // unreset flops power up unknown; the first clock settles them
        if (phase_set_q !== 1'b1) begin
            phase_d = i_phase_strap;
        end
        div_d = (div_q === 1'b1) ? 1'b0 : 1'b1;
    end

    // divider lives outside reset so resets never move its phase
    always_ff @(posedge i_ref_clk) begin
        div_q <= div_d;
    end

    always_ff @(posedge i_ref_clk) begin
        phase_q <= phase_d;
        phase_set_q <= phase_set_d;
    end

    assign o_half_rate_clock_output = (div_q === 1'bx) ? 1'b0
        : (div_q ^ phase_q);

    // both forwarded clock and bus come from the far side
    always_comb begin
        fclk_s_d = {fclk_s_q[0], i_forwarded_sample_clock};
        bus_s0_d = i_sample_bus;
        bus_s1_d = bus_s0_q;
        fclk_prev_d = fclk_s_q[1];
        arm_d = {arm_q[1:0], 1'b1};
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            fclk_s_q <= '0;
            bus_s0_q <= '0;
            bus_s1_q <= '0;
            fclk_prev_q <= 1'b0;
            arm_q <= '0;
        end else begin
            fclk_s_q <= fclk_s_d;
            bus_s0_q <= bus_s0_d;
            bus_s1_q <= bus_s1_d;
            fclk_prev_q <= fclk_prev_d;
            arm_q <= arm_d;
        end
    end

    // any edge, rising or falling, is a ddr launch point; the arm stage
    // keeps a pin left high across reset from posing as an edge
    assign edge_seen = arm_q[2] && (fclk_s_q[1] ^ fclk_prev_q);

    always_comb begin
        // strobe fires one cycle after the edge: mid-window sample
        strobe_d = edge_seen;
        upper_d = upper_q;
        lower_d = lower_q;
        sel_d = sel_q;
        pair_v_d = pair_v_q && !pair_if.ready;
        if (strobe_q) begin
            sel_d = ~sel_q;
            if (!sel_q) begin
                upper_d = bus_s1_q;
            end else begin
                lower_d = bus_s1_q;
                pair_v_d = 1'b1;
            end
        end
    end

    assign pair_if.valid = pair_v_q;
    assign pair_if.upper = upper_q;
    assign pair_if.lower = lower_q;

    // controller tracks edges while enabled; off means external timing
    always_comb begin
        ctl_d = ctl_q;
        lock_d = lock_q;
        case (ctl_q)
            DSF_SEEK: begin
                if (i_ctl_enable && edge_seen) begin
                    lock_d = lock_q + 4'h1;
                    if (lock_q == `DSF_LOCK_CYC) begin
                        ctl_d = DSF_TRACK;
                    end
                end
            end
            DSF_TRACK: begin
                if (!i_ctl_enable) begin
                    ctl_d = DSF_SEEK;
                    lock_d = '0;
                end
            end
            default: begin
                ctl_d = DSF_SEEK;
                lock_d = '0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            strobe_q <= 1'b0;
            upper_q <= '0;
            lower_q <= '0;
            sel_q <= 1'b0;
            pair_v_q <= 1'b0;
        end else begin
            strobe_q <= strobe_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            sel_q <= sel_d;
            pair_v_q <= pair_v_d;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= DSF_SEEK;
            lock_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            lock_q <= lock_d;
        end
    end

    assign o_locked = (ctl_q == DSF_TRACK);
    // fifo path has no defined latency, so report it as unfixed
    assign o_latency_fixed = !i_fifo_enable && !i_ctl_enable;

    dsf_skid_buf #(
        .DEPTH(2)
    ) u_buf (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .in_if(pair_if),
        .o_valid(o_valid),
        .i_ready(i_ready),
        .o_upper(o_upper_sample_path),
        .o_lower(o_lower_sample_path)
    );
endmodule : dsf_feed_top

// File: hw/dsf_pair_if.sv
// carrier for upper and lower sample paths between feed and buffer
`timescale 1ns/100ps
interface dsf_pair_if;
    import dsf_pkg::*;
    logic valid;
    logic ready;
    dsf_sample_t upper;
    dsf_sample_t lower;
    modport src (output valid, output upper, output lower, input ready);
    modport snk (input valid, input upper, input lower, output ready);
endinterface : dsf_pair_if

// File: hw/dsf_pkg.sv
// types for the sample feed clocking block
`include "dsf_regs.svh"
package dsf_pkg;
    typedef logic [`DSF_SAMPLE_W-1:0] dsf_sample_t;
    typedef enum logic [1:0] {
        DSF_BYPASS,
        DSF_INTERP2
    } dsf_mode_t;
    typedef enum logic [1:0] {
        DSF_SEEK,
        DSF_TRACK
    } dsf_ctl_t;
endpackage : dsf_pkg

// File: hw/dsf_regs.svh
// constants for the sample feed clocking block
`ifndef DSF_REGS_SVH
`define DSF_REGS_SVH
`define DSF_SAMPLE_W 14
`define DSF_PHASE_0 1'h0
`define DSF_PHASE_180 1'h1
`define DSF_SETTLE_CYC 4'h3
`define DSF_LOCK_CYC 4'h8
`endif

// File: hw/dsf_skid_buf.sv
// two-entry buffer for de-interleaved sample pairs
`timescale 1ns/100ps
module dsf_skid_buf
    import dsf_pkg::*;
#(
    parameter int DEPTH = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    dsf_pair_if.snk in_if,
    output logic o_valid,
    input wire logic i_ready,
    output dsf_sample_t o_upper,
    output dsf_sample_t o_lower
);
    localparam int AW = $clog2(DEPTH);
    dsf_sample_t mem_u_q [DEPTH];
    dsf_sample_t mem_l_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_if.ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_upper = mem_u_q[rd_q];
    assign o_lower = mem_l_q[rd_q];
    assign push = in_if.valid && in_if.ready;
    assign pop = o_valid && i_ready;

    always_comb begin
        wr_d = push ? bump(wr_q) : wr_q;
        rd_d = pop ? bump(rd_q) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            for (int k = 0; k < DEPTH; k++) begin
                mem_u_q[k] <= '0;
                mem_l_q[k] <= '0;
            end
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            if (push) begin
                mem_u_q[wr_q] <= in_if.upper;
                mem_l_q[wr_q] <= in_if.lower;
            end
        end
    end
endmodule : dsf_skid_buf

// File: sim/dsf_feed_monitor.sv
// checker for the sample feed clocking block
`timescale 1ns/100ps
module dsf_feed_monitor
    import dsf_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ctl_enable,
    input wire logic i_fifo_enable,
    input wire logic i_forwarded_sample_clock,
    input wire logic i_ready,
    input wire logic o_half_rate_clock_output,
    input wire logic o_valid,
    input wire dsf_sample_t o_upper_sample_path,
    input wire dsf_sample_t o_lower_sample_path,
    input wire logic o_latency_fixed,
    input wire logic o_locked
);
    logic hr_q;
    // value just before each rising edge
    always_ff @(posedge i_ref_clk) hr_q <= o_half_rate_clock_output;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    half_rate_a:
        assert property (o_half_rate_clock_output != hr_q) else $error("hr");
    edge_only_a:
        assert property (@(negedge i_ref_clk) disable iff (i_rst)
        o_half_rate_clock_output != hr_q) else $error("hr edge");
    phase_kept_a:
        assert property ($fell(i_rst) |-> o_half_rate_clock_output
        != $past(o_half_rate_clock_output)) else $error("hr reset");
    pair_hold_a:
        assert property (o_valid && !i_ready |=> o_valid
        && $stable(o_upper_sample_path) && $stable(o_lower_sample_path))
        else $error("pair hold");
    pair_cause_a:
        assert property ($rose(o_valid) |-> $past(i_forwarded_sample_clock, 4)
        != $past(i_forwarded_sample_clock, 6)) else $error("pair cause");
    lock_ctl_a:
        assert property ($rose(o_locked) |-> $past(i_ctl_enable))
        else $error("lock");
    lock_keep_a:
        assert property (o_locked && i_ctl_enable |=> o_locked)
        else $error("lock keep");
    fixed_lat_a:
        assert property (o_latency_fixed == (!i_fifo_enable && !i_ctl_enable))
        else $error("latency");
    cover property (o_valid && i_ready);
    cover property (o_valid && !i_ready ##1 o_valid);
    cover property ($rose(o_locked));
endmodule : dsf_feed_monitor
bind dsf_feed_top dsf_feed_monitor u_mon (.*);

// File: sim/dsf_src_model.sv
// sample source on the far side of the ddr feed
`timescale 1ns/100ps
module dsf_src_model
    import dsf_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_half,
    input wire logic i_x2,
    output logic o_fwd,
    output dsf_sample_t o_bus
);
    initial begin
        o_fwd = 1'b0;
        o_bus = '0;
    end
    // data leads the edge, then turns over so no stale word lingers
    task automatic send(input dsf_sample_t w);
        @(posedge i_ref_clk);
        o_bus <= w;
        // 2x: divide the received half-rate clock by two first
        repeat (i_x2 ? 2 : 1) @(posedge i_ref_clk iff i_half === 1'b1);
        o_fwd <= ~o_fwd;
        repeat (4) @(posedge i_ref_clk);
        o_bus <= ~w;
    endtask : send
endmodule : dsf_src_model

// File: sim/tb.sv
// self-checking bench for the sample feed clocking block
`timescale 1ns/100ps
module tb;
    import dsf_pkg::*;
    logic clk, rst, strap, ctl, fifo, fwd, rdy, half, vld, fixed, lock, x2;
    dsf_sample_t bus, up, lo;
    int err_count = 0;
    int checked = 0;
    dsf_feed_top u_dut (.i_ref_clk(clk), .i_rst(rst), .i_phase_strap(strap),
        .i_ctl_enable(ctl), .i_fifo_enable(fifo),
        .i_forwarded_sample_clock(fwd), .i_sample_bus(bus), .i_ready(rdy),
        .o_half_rate_clock_output(half), .o_valid(vld),
        .o_upper_sample_path(up), .o_lower_sample_path(lo),
        .o_latency_fixed(fixed), .o_locked(lock));
    dsf_src_model u_src (.i_ref_clk(clk), .i_half(half), .i_x2(x2),
        .o_fwd(fwd), .o_bus(bus));
    task automatic close_out();
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    task automatic get_pair(input dsf_sample_t u, input dsf_sample_t l);
        int n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (vld !== 1'b1 && n < 50);
        chk(n < 50 && up === u && lo === l, "pair mismatch");
        if (n >= 50) close_out();
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
    endtask : get_pair
    task automatic t_pairs();
        u_src.send(14'h3FFF);
        u_src.send(14'h0000);
        get_pair(14'h3FFF, 14'h0000);
        u_src.send(14'h2AAA);
        u_src.send(14'h1555);
        get_pair(14'h2AAA, 14'h1555);
    endtask : t_pairs
    task automatic t_stall();
        u_src.send(14'h0123);
        u_src.send(14'h3210);
        u_src.send(14'h1F0F);
        u_src.send(14'h20F0);
        u_src.send(14'h0F0F);
        u_src.send(14'h30C3);
        repeat (8) @(posedge clk);
        get_pair(14'h0123, 14'h3210);
        get_pair(14'h1F0F, 14'h20F0);
        get_pair(14'h0F0F, 14'h30C3);
    endtask : t_stall
    task automatic t_flags();
        chk(lock === 1'b1, "not locked");
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {ctl, fifo} <= k[1:0];
            @(posedge clk);
            #1;
            chk(fixed === (k == 0), "latency flag");
        end
    endtask : t_flags
    task automatic t_reset();
        logic p;
        @(posedge clk);
        strap <= 1'b1;
        rst <= 1'b1;
        #1;
        p = half;
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            if (k == 2) begin
                rst <= 1'b0;
            end
            #1;
            chk(half === ~p, "half-rate step");
            p = half;
        end
        chk(vld === 1'b0 && lock === 1'b0 && up === '0, "reset state");
        x2 <= 1'b1;
        u_src.send(14'h0ABC);
        u_src.send(14'h3CBA);
        get_pair(14'h0ABC, 14'h3CBA);
    endtask : t_reset
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        ctl = 1'b1;
        fifo = 1'b0;
        rdy = 1'b0;
        x2 = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_pairs();
        t_stall();
        t_flags();
        t_reset();
        close_out();
    end
endmodule : tb
